// File: hdl/ars_dummy_unused.v
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

// File: hdl/ars_regs.vh
`ifndef ARS_REGS_VH
`define ARS_REGS_VH
// ----------------------------------------------------------------------
// Sequencer states, one-hot.
// ----------------------------------------------------------------------
`define ARS_ST_IDLE 5'h01
`define ARS_ST_WAKE 5'h02
`define ARS_ST_SAMP 5'h04
`define ARS_ST_CONV 5'h08
`define ARS_ST_DONE 5'h10
// ----------------------------------------------------------------------
// Data reduction modes.
// ----------------------------------------------------------------------
`define ARS_RED_NONE 2'h0
`define ARS_RED_LIM  2'h1
`define ARS_RED_ACC  2'h2
// ----------------------------------------------------------------------
// Request source numbers, also the tie-break order.
// ----------------------------------------------------------------------
`define ARS_SRC_PAR 2'h0
`define ARS_SRC_Q   2'h1
`define ARS_SRC_INS 2'h2
`define ARS_SRC_NO  2'h3
// ----------------------------------------------------------------------
// Trigger selection and timing.
// ----------------------------------------------------------------------
`define ARS_TSEL_EXT  3'h4
`define ARS_BIT_MSB   4'h9
`define ARS_BIT_LSB8  4'h2
`define ARS_PWRUP_NS  20
`define ARS_CLK_NS    5
`endif

// File: hdl/ars_sequencer.v
// Function
// - Results are 10 bits by default; an 8-bit mode ends conversion early.
// - Converter selects 16 inputs through its channel select.
// - Sampling and conversion phase lengths come from programmable cycle counts.
// - Two converters can start sampling together on the same clock edge.
// - External multiplexer select advances with each conversion when enabled.
// - Unused channel pins stay readable as digital inputs.
// - Parallel requests pend together and convert in ascending channel order.
// - Queued requests convert in the order software pushed them.
// - One inserted conversion runs between sequence steps, losing nothing.
// - The arbiter grants the pending source with the highest priority.
// - Parallel source starts by software, internal events or external trigger.
// - Results can be limit-checked or accumulated before being reported.
// - Eight result registers, optionally chained as a result FIFO.
// - Wait-for-read holds a conversion until its unread target is read.
// - Selectable result and limit event requests pulse for software or transfer.
// - Per-pin disable bits cut each pin from its digital input stage.
// - Auto power-down switches the converter off when idle with no request pending.
// - Per-channel broken-wire precharge and a multiplexer test mode.
`timescale 1ns/1ps
`include "ars_regs.vh"
`default_nettype none
module ars_sequencer #(
    parameter NCH = 16,
    parameter CW  = 4,
    parameter QD  = 4,
    parameter QAW = 2
) (
    input  wire            i_clock,
    input  wire            i_srst,
    input  wire            i_ce,
    input  wire            i_cmp,
    output reg  [9:0]      o_dac,
    output wire            o_sample,
    output reg  [CW-1:0]   o_ch_sel,
    output wire            o_precharge,
    output wire            o_mux_test,
    output wire            o_pwr_on,
    output wire            o_busy,
    input  wire            i_res8,
    input  wire [7:0]      i_stc,
    input  wire [7:0]      i_ctc,
    input  wire            i_sync_slave,
    input  wire            i_sync_go,
    output wire            o_sync_go,
    input  wire            i_emux_en,
    output reg  [2:0]      o_emux_sel,
    input  wire [NCH-1:0]  i_din_pins,
    input  wire [NCH-1:0]  i_din_dis,
    output reg  [NCH-1:0]  o_din,
    input  wire [NCH-1:0]  i_par_mask,
    input  wire            i_par_sw,
    input  wire [2:0]      i_par_tsel,
    input  wire [3:0]      i_trig_int,
    input  wire            i_trig_ext,
    input  wire [1:0]      i_par_prio,
    input  wire            i_q_valid,
    input  wire [CW-1:0]   i_q_chan,
    output wire            o_q_ready,
    input  wire [1:0]      i_q_prio,
    input  wire            i_ins_valid,
    input  wire [CW-1:0]   i_ins_chan,
    output wire            o_ins_ready,
    input  wire [1:0]      i_ins_prio,
    input  wire            i_fifo_en,
    input  wire [7:0]      i_wfr,
    input  wire            i_rd,
    input  wire [2:0]      i_rd_idx,
    output reg  [11:0]     o_rd_data,
    output reg  [CW-1:0]   o_rd_chan,
    output reg  [7:0]      o_res_valid,
    input  wire [1:0]      i_red_mode,
    input  wire [9:0]      i_lim_lo,
    input  wire [9:0]      i_lim_hi,
    input  wire [1:0]      i_acc_num,
    input  wire            i_apd_en,
    input  wire [NCH-1:0]  i_bwd_en,
    input  wire            i_mux_test,
    input  wire [1:0]      i_evt_en,
    output reg             o_res_evt,
    output reg             o_lim_evt
);
    // Power-up wait rounded up to whole cycles.
    localparam [7:0] PWRUP_CYC = (`ARS_PWRUP_NS + `ARS_CLK_NS - 1) / `ARS_CLK_NS;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Lowest set bit wins, which fixes the parallel conversion order.
    function [CW-1:0] low_bit;
        input [NCH-1:0] v;
        integer k;
        begin
            low_bit = {CW{1'b0}};
            for (k = NCH - 1; k >= 0; k = k - 1) begin
                if (v[k]) begin
                    low_bit = k[CW-1:0];
                end
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    reg  [4:0]     st_q;
    reg  [7:0]     cnt_q;
    reg  [3:0]     bit_q;
    reg  [1:0]     src_q;
    reg            pwr_q;
    reg  [NCH-1:0] pend_q;
    reg  [CW-1:0]  qmem [0:QD-1];
    reg  [QAW-1:0] qwp_q;
    reg  [QAW-1:0] qrp_q;
    reg  [QAW:0]   qcnt_q;
    reg            ins_v_q;
    reg  [CW-1:0]  ins_ch_q;
    reg  [11:0]    res_mem [0:7];
    reg  [CW-1:0]  chn_mem [0:7];
    reg  [2:0]     wp_q;
    reg  [2:0]     rp_q;
    reg  [11:0]    acc_q;
    reg  [1:0]     acc_n_q;
    reg            cmp_m_q;
    reg            cmp_s_q;
    reg            ext_m_q;
    reg            ext_s_q;
    reg            ext_p_q;
    reg  [NCH-1:0] din_m_q;

    // ------------------------------------------------------------------
    // Trigger, arbitration and start condition
    // ------------------------------------------------------------------
    wire       ext_edge = ext_s_q & ~ext_p_q;
    wire       par_trig = i_par_sw |
                          ((i_par_tsel == `ARS_TSEL_EXT) & ext_edge) |
                          (~i_par_tsel[2] & i_trig_int[i_par_tsel[1:0]]);
    wire       q_push   = i_q_valid & o_q_ready;
    wire       ins_push = i_ins_valid & o_ins_ready;
    wire       par_req  = |pend_q;
    wire       q_req    = (qcnt_q != {(QAW+1){1'b0}});
    reg  [1:0] win;
    reg  [1:0] win_p;
    reg  [CW-1:0] win_ch;

    // Highest priority wins; strict compares keep ties on the lower source.
    always @* begin
        win   = `ARS_SRC_NO;
        win_p = 2'h0;
        if (par_req) begin
            win   = `ARS_SRC_PAR;
            win_p = i_par_prio;
        end
        if (q_req && (win == `ARS_SRC_NO || i_q_prio > win_p)) begin
            win   = `ARS_SRC_Q;
            win_p = i_q_prio;
        end
        if (ins_v_q && (win == `ARS_SRC_NO || i_ins_prio > win_p)) begin
            win   = `ARS_SRC_INS;
            win_p = i_ins_prio;
        end
        case (win)
            `ARS_SRC_PAR: win_ch = low_bit(pend_q);
            `ARS_SRC_Q:   win_ch = qmem[qrp_q];
            `ARS_SRC_INS: win_ch = ins_ch_q;
            default:      win_ch = {CW{1'b0}};
        endcase
    end

    // A start is held off while the target result is unread under wait-for-read.
    wire [2:0] tgt     = i_fifo_en ? wp_q : win_ch[2:0];
    wire       blocked = i_wfr[tgt] & o_res_valid[tgt];
    wire       req     = (win != `ARS_SRC_NO);
    wire       go_ok   = req & ~blocked & pwr_q & (st_q == `ARS_ST_IDLE);
    wire       start   = go_ok & (~i_sync_slave | i_sync_go);
    assign o_sync_go   = start;
    assign o_q_ready   = (qcnt_q != QD);
    assign o_ins_ready = ~ins_v_q;
    assign o_sample    = (st_q == `ARS_ST_SAMP);
    assign o_busy      = (st_q != `ARS_ST_IDLE);
    assign o_pwr_on    = pwr_q;
    // Broken-wire check precharges the input during the first sampling cycle.
    assign o_precharge = o_sample & i_bwd_en[o_ch_sel] & (cnt_q == 8'h00);
    assign o_mux_test  = i_mux_test & o_busy;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Comparator, trigger and port pins are asynchronous; two stages each.
    always @(posedge i_clock) begin
        if (i_srst) begin
            cmp_m_q <= 1'b0;
            cmp_s_q <= 1'b0;
            ext_m_q <= 1'b0;
            ext_s_q <= 1'b0;
            ext_p_q <= 1'b0;
            din_m_q <= {NCH{1'b0}};
            o_din   <= {NCH{1'b0}};
        end else if (i_ce) begin
            cmp_m_q <= i_cmp;
            cmp_s_q <= cmp_m_q;
            ext_m_q <= i_trig_ext;
            ext_s_q <= ext_m_q;
            ext_p_q <= ext_s_q;
            din_m_q <= i_din_pins;
            o_din   <= din_m_q & ~i_din_dis;
        end
    end

    // ------------------------------------------------------------------
    // Request sources
    // ------------------------------------------------------------------
    // Pending bits set wins over the clear of the channel being started.
    always @(posedge i_clock) begin
        if (i_srst) begin
            pend_q   <= {NCH{1'b0}};
            qwp_q    <= {QAW{1'b0}};
            qrp_q    <= {QAW{1'b0}};
            qcnt_q   <= {(QAW+1){1'b0}};
            ins_v_q  <= 1'b0;
            ins_ch_q <= {CW{1'b0}};
        end else if (i_ce) begin
            pend_q <= (pend_q & ~((start && win == `ARS_SRC_PAR) ?
                      ({{(NCH-1){1'b0}}, 1'b1} << win_ch) : {NCH{1'b0}})) |
                      (par_trig ? i_par_mask : {NCH{1'b0}});
            if (q_push) begin
                qmem[qwp_q] <= i_q_chan;
                qwp_q       <= qwp_q + 1'b1;
            end
            if (start && win == `ARS_SRC_Q) begin
                qrp_q <= qrp_q + 1'b1;
            end
            qcnt_q <= qcnt_q + {{QAW{1'b0}}, q_push} -
                      {{QAW{1'b0}}, (start && win == `ARS_SRC_Q)};
            // Other sources keep their state while the insert converts.
            if (ins_push) begin
                ins_v_q  <= 1'b1;
                ins_ch_q <= i_ins_chan;
            end else if (start && win == `ARS_SRC_INS) begin
                ins_v_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Converter sequencing
    // ------------------------------------------------------------------
    // The comparator is sampled after the synchroniser, so each step needs
    // a conversion count of at least two to see a settled decision.
    always @(posedge i_clock) begin
        if (i_srst) begin
            st_q       <= `ARS_ST_IDLE;
            cnt_q      <= 8'h00;
            bit_q      <= `ARS_BIT_MSB;
            src_q      <= `ARS_SRC_NO;
            pwr_q      <= 1'b0;
            o_dac      <= 10'h000;
            o_ch_sel   <= {CW{1'b0}};
            o_emux_sel <= 3'h0;
        end else if (i_ce) begin
            case (st_q)
                `ARS_ST_IDLE: begin
                    if (!i_apd_en) begin
                        pwr_q <= 1'b1;
                    end else if (!req) begin
                        pwr_q <= 1'b0;
                    end
                    if (req && !pwr_q) begin
                        st_q  <= `ARS_ST_WAKE;
                        pwr_q <= 1'b1;
                        cnt_q <= 8'h00;
                    end else if (start) begin
                        st_q     <= `ARS_ST_SAMP;
                        src_q    <= win;
                        o_ch_sel <= win_ch;
                        cnt_q    <= 8'h00;
                    end
                end
                `ARS_ST_WAKE: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q == PWRUP_CYC - 8'h01) begin
                        st_q <= `ARS_ST_IDLE;
                    end
                end
                `ARS_ST_SAMP: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q >= i_stc) begin
                        st_q  <= `ARS_ST_CONV;
                        cnt_q <= 8'h00;
                        bit_q <= `ARS_BIT_MSB;
                        o_dac <= 10'h200;
                    end
                end
                `ARS_ST_CONV: begin
                    cnt_q <= cnt_q + 8'h01;
                    if (cnt_q >= i_ctc) begin
                        cnt_q <= 8'h00;
                        o_dac <= (cmp_s_q ? o_dac : (o_dac & ~(10'h001 << bit_q))) |
                                 ((bit_q != 4'h0) ? (10'h001 << (bit_q - 4'h1)) : 10'h000);
                        if (bit_q == (i_res8 ? `ARS_BIT_LSB8 : 4'h0)) begin
                            st_q  <= `ARS_ST_DONE;
                            o_dac <= cmp_s_q ? o_dac : (o_dac & ~(10'h001 << bit_q));
                        end else begin
                            bit_q <= bit_q - 4'h1;
                        end
                    end
                end
                `ARS_ST_DONE: begin
                    st_q <= `ARS_ST_IDLE;
                    if (i_emux_en) begin
                        o_emux_sel <= o_emux_sel + 3'h1;
                    end else begin
                        o_emux_sel <= 3'h0;
                    end
                end
                default: begin
                    st_q <= `ARS_ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Result handling
    // ------------------------------------------------------------------
    wire [9:0]  raw     = i_res8 ? {2'h0, o_dac[9:2]} : o_dac;
    wire        done    = (st_q == `ARS_ST_DONE);
    wire        outside = (raw < i_lim_lo) | (raw > i_lim_hi);
    wire [11:0] acc_sum = acc_q + {2'h0, raw};
    wire        acc_end = (acc_n_q == i_acc_num);
    wire        store   = done & ((i_red_mode == `ARS_RED_NONE) |
                          ((i_red_mode == `ARS_RED_LIM) & outside) |
                          ((i_red_mode == `ARS_RED_ACC) & acc_end));
    wire [11:0] sval    = (i_red_mode == `ARS_RED_ACC) ? acc_sum : {2'h0, raw};
    wire [2:0]  sidx    = i_fifo_en ? wp_q : o_ch_sel[2:0];
    wire [2:0]  ridx    = i_fifo_en ? rp_q : i_rd_idx;
    wire        rd_ok   = i_rd & (~i_fifo_en | o_res_valid[rp_q]);
    reg  [7:0]  vset;
    reg  [7:0]  vclr;

    // Valid flags: a store in the read cycle keeps the flag set.
    always @* begin
        vset = 8'h00;
        vclr = 8'h00;
        if (store) begin
            vset[sidx] = 1'b1;
        end
        if (rd_ok) begin
            vclr[ridx] = 1'b1;
        end
    end

    // Store, read and event pulses; FIFO pointers wrap over eight entries.
    always @(posedge i_clock) begin
        if (i_srst) begin
            o_res_valid <= 8'h00;
            o_rd_data   <= 12'h000;
            o_rd_chan   <= {CW{1'b0}};
            wp_q        <= 3'h0;
            rp_q        <= 3'h0;
            acc_q       <= 12'h000;
            acc_n_q     <= 2'h0;
            o_res_evt   <= 1'b0;
            o_lim_evt   <= 1'b0;
        end else if (i_ce) begin
            o_res_valid <= (o_res_valid & ~vclr) | vset;
            o_res_evt   <= store & i_evt_en[0];
            o_lim_evt   <= done & (i_red_mode == `ARS_RED_LIM) &
                           outside & i_evt_en[1];
            if (store) begin
                res_mem[sidx] <= sval;
                chn_mem[sidx] <= o_ch_sel;
                if (i_fifo_en) begin
                    wp_q <= wp_q + 3'h1;
                end
            end
            if (rd_ok) begin
                o_rd_data <= res_mem[ridx];
                o_rd_chan <= chn_mem[ridx];
                if (i_fifo_en) begin
                    rp_q <= rp_q + 3'h1;
                end
            end
            if (done && i_red_mode == `ARS_RED_ACC) begin
                acc_q   <= acc_end ? 12'h000 : acc_sum;
                acc_n_q <= acc_end ? 2'h0 : acc_n_q + 2'h1;
            end
        end
    end
endmodule
`default_nettype wire

// File: tb/ars_sequencer_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Port checker for one converter sequencer.
// ----------------------------------------------------------------------
module ars_sequencer_chk #(
    parameter NCH = 16
) (
    input wire logic           i_clock,
    input wire logic           i_srst,
    input wire logic           i_ce,
    input wire logic           i_mux_test,
    input wire logic [NCH-1:0] i_din_dis,
    input wire logic [1:0]     i_evt_en,
    input wire logic [1:0]     i_red_mode,
    input wire logic           i_apd_en,
    input wire logic           i_emux_en,
    input wire logic           o_sample,
    input wire logic           o_busy,
    input wire logic           o_precharge,
    input wire logic           o_mux_test,
    input wire logic           o_sync_go,
    input wire logic [NCH-1:0] o_din,
    input wire logic           o_res_evt,
    input wire logic           o_lim_evt,
    input wire logic           o_pwr_on,
    input wire logic [2:0]     o_emux_sel
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // Relations between control inputs and the sequencer outputs.
    a_samp_busy: assert property (o_sample |-> o_busy && o_pwr_on)
        else $error("sampling while idle or unpowered");
    a_mux_test: assert property (o_mux_test == (i_mux_test && o_busy))
        else $error("mux test output wrong");
    a_precharge_first: assert property (o_precharge |-> o_sample && !$past(o_sample))
        else $error("precharge outside first sample cycle");
    a_sync_start: assert property (o_sync_go |=> o_sample)
        else $error("sync start not followed by sampling");
    a_din_masked: assert property ($past(i_ce) && !$past(i_srst) |->
        (o_din & $past(i_din_dis)) == '0)
        else $error("disabled pin reaches digital input");
    a_evt_pulse: assert property (o_res_evt |=> !o_res_evt)
        else $error("result event longer than one cycle");
    a_evt_enable: assert property (o_lim_evt |-> $past(i_evt_en[1])
        && $past(i_red_mode) == 2'h1)
        else $error("limit event without enable");
    a_apd_off: assert property ((i_apd_en && !o_busy) [*3] |-> !o_pwr_on)
        else $error("converter powered while idle");
    a_emux_off: assert property (!i_emux_en && !$past(i_emux_en) && !$past(i_srst)
        |-> o_emux_sel == 3'h0)
        else $error("mux select moves while disabled");
    c_res: cover property (o_res_evt);
    c_lim: cover property (o_lim_evt);
    c_sync: cover property (o_sync_go);
    c_pre: cover property (o_precharge);
endmodule
bind ars_sequencer ars_sequencer_chk #(.NCH(NCH)) u_chk (.*);
`default_nettype wire

// File: tb/ars_src_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Analog source and comparator model.
// ----------------------------------------------------------------------
module ars_src_model (
    input  wire logic [3:0] i_ch_sel,
    input  wire logic [9:0] i_dac,
    output var  logic       o_cmp
);
    logic [11:0] level;
    // Channel n holds the steady level n*61+5, from 5 on channel 0 to 920 on channel 15.
    // The sensor is ideal: no settling lag, so only timing faults show up.
    always_comb begin
        level = {8'h00, i_ch_sel} * 12'h03D + 12'h005;
        o_cmp = level >= {2'h0, i_dac};
    end
endmodule
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench for one converter sequencer.
// ----------------------------------------------------------------------
module tb_top;
    logic        i_clock = 0, i_srst = 1, i_res8 = 0, i_sync_slave = 0, i_sync_go = 0, i_ce = 1;
    logic        i_emux_en = 0, i_par_sw = 0, i_trig_ext = 0, i_q_valid = 0, i_ins_valid = 0;
    logic        i_fifo_en = 0, i_rd = 0, i_apd_en = 0, i_mux_test = 1;
    logic [1:0]  i_par_prio = 0, i_q_prio = 0, i_ins_prio = 0, i_red_mode = 0, i_acc_num = 0;
    logic [1:0]  i_evt_en = 2'h3;
    logic [2:0]  i_par_tsel = 3'h7, i_rd_idx = 0;
    logic [3:0]  i_trig_int = 0, i_q_chan = 0, i_ins_chan = 0;
    logic [7:0]  i_stc = 8'h02, i_ctc = 8'h03, i_wfr = 0;
    logic [9:0]  i_lim_lo = 0, i_lim_hi = 10'h3FF;
    logic [15:0] i_din_pins = 16'hA5C3, i_din_dis = 16'h00FF, i_par_mask = 0;
    logic [15:0] i_bwd_en = 16'h0020;
    wire         i_cmp, o_sample, o_precharge, o_mux_test, o_pwr_on, o_busy, o_sync_go;
    wire         o_q_ready, o_ins_ready, o_res_evt, o_lim_evt;
    wire  [9:0]  o_dac;
    wire  [3:0]  o_ch_sel, o_rd_chan;
    wire  [2:0]  o_emux_sel;
    wire  [15:0] o_din;
    wire  [11:0] o_rd_data;
    wire  [7:0]  o_res_valid;
    int          fail_count = 0, checked = 0, cyc = 0, res_n = 0, lim_n = 0, l0;
    logic [3:0]  seen[$];
    logic        smp_q = 0;
    always #2.5 i_clock = ~i_clock;
    ars_sequencer DUT (.*);
    ars_src_model u_src (.i_ch_sel(o_ch_sel), .i_dac(o_dac), .o_cmp(i_cmp));
    // Channel order log and cycle ceiling.
    always @(posedge i_clock) begin
        cyc <= cyc + 1;
        if (o_sample === 1'b1 && smp_q !== 1'b1) seen.push_back(o_ch_sel);
        smp_q <= o_sample;
        if (o_res_evt === 1'b1) res_n <= res_n + 1;
        if (o_lim_evt === 1'b1) lim_n <= lim_n + 1;
        if (cyc == 30000) begin
            fail_count = fail_count + 1;
            conclude();
        end
    end
    function automatic logic [11:0] lvl(input logic [3:0] ch);
        lvl = {8'h00, ch} * 12'h03D + 12'h005;
    endfunction
    task automatic conclude;
        if (fail_count == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
    endtask
    // Requests hold until the ready that goes with them is seen at an edge.
    task automatic push(input logic ins, input logic [3:0] ch);
        @(posedge i_clock);
        i_q_valid <= !ins;
        i_ins_valid <= ins;
        i_q_chan <= ch;
        i_ins_chan <= ch;
        do @(posedge i_clock); while ((ins ? o_ins_ready : o_q_ready) !== 1'b1);
        i_q_valid <= 1'b0;
        i_ins_valid <= 1'b0;
    endtask
    task automatic sw;
        @(posedge i_clock);
        i_par_sw <= 1'b1;
        @(posedge i_clock);
        i_par_sw <= 1'b0;
    endtask
    task automatic wait_res(input int n);
        int t;
        t = res_n + n;
        for (int k = 0; k < 2000 && res_n < t; k++) @(posedge i_clock);
    endtask
    // Idle means four quiet cycles, since busy may drop briefly between queued requests.
    task automatic wait_idle;
        int q;
        q = 0;
        for (int k = 0; k < 3000 && q < 4; k++) begin
            @(posedge i_clock);
            q = (o_busy === 1'b0) ? q + 1 : 0;
        end
    endtask
    task automatic rd(input logic [2:0] idx, input logic [11:0] e, input logic [3:0] ch);
        @(posedge i_clock);
        i_rd <= 1'b1;
        i_rd_idx <= idx;
        @(posedge i_clock);
        i_rd <= 1'b0;
        #1;
        chk("rd_data", e, o_rd_data);
        chk("rd_chan", ch, o_rd_chan);
        if (!i_fifo_en) chk("valid_clr", 0, o_res_valid[idx]);
    endtask
    task automatic chk_seq(input logic [11:0] s);
        chk("order", s, {seen[0], seen[1], seen[2]});
        seen.delete();
    endtask
    // Main sequence of scenarios.
    initial begin
        tick(2);
        i_srst <= 1'b0;
        i_sync_slave <= 1'b1;
        push(0, 4'h1);
        tick(20);
        #1 chk("sync_wait", 0, o_sample);
        @(posedge i_clock);
        i_sync_go <= 1'b1;
        i_sync_slave <= 1'b0;
        @(posedge i_clock);
        i_sync_go <= 1'b0;
        #1 chk("sync_samp", 1, o_sample);
        wait_res(1);
        rd(1, lvl(1), 1);
        seen.delete();
        push(0, 4'h5);
        push(0, 4'h2);
        push(0, 4'h6);
        wait_res(3);
        chk_seq(12'h526);
        #1 chk("valid", 8'h64, o_res_valid);
        rd(5, lvl(5), 5);
        @(posedge i_clock);
        i_par_mask <= 16'h0212;
        sw();
        wait_res(3);
        chk_seq(12'h149);
        rd(1, lvl(9), 9);
        for (int t = 0; t < 5; t++) begin
            @(posedge i_clock);
            i_par_tsel <= t[2:0];
            i_par_mask <= 16'h0100 << t;
            @(posedge i_clock);
            if (t < 4) i_trig_int <= 4'h1 << t;
            else i_trig_ext <= 1'b1;
            tick(t < 4 ? 1 : 3);
            i_trig_int <= 4'h0;
            i_trig_ext <= 1'b0;
            wait_res(1);
            rd(t[2:0], lvl(4'h8 + t[3:0]), 4'h8 + t[3:0]);
        end
        for (int c = 0; c < 3; c++) begin
            @(posedge i_clock);
            i_par_tsel <= 3'h7;
            i_q_prio <= (c == 0) ? 2'h2 : 2'h1;
            i_par_prio <= 2'h1;
            i_ins_prio <= 2'h3;
            i_par_mask <= 16'h0001;
            seen.delete();
            push(0, 4'h5);
            push(0, c == 2 ? 4'h6 : 4'h7);
            if (c == 2) push(1, 4'h2);
            else sw();
            wait_res(3);
            chk_seq(c == 0 ? 12'h570 : (c == 1 ? 12'h507 : 12'h526));
        end
        @(posedge i_clock);
        i_res8 <= 1'b1;
        i_stc <= 8'h05;
        push(0, 4'hB);
        wait_res(1);
        rd(3, lvl(4'hB) >> 2, 4'hB);
        @(posedge i_clock);
        i_res8 <= 1'b0;
        i_red_mode <= 2'h1;
        push(0, 4'hC);
        wait_idle();
        l0 = lim_n;
        chk("lim_in", 0, o_res_valid[4]);
        i_lim_hi <= 10'(lvl(4'hC) - 12'h001);
        push(0, 4'hC);
        wait_idle();
        chk("lim_evt", l0 + 1, lim_n);
        rd(4, lvl(4'hC), 4'hC);
        @(posedge i_clock);
        i_red_mode <= 2'h2;
        i_acc_num <= 2'h1;
        push(0, 4'hD);
        push(0, 4'hD);
        wait_idle();
        rd(5, lvl(4'hD) * 2, 4'hD);
        @(posedge i_clock);
        i_red_mode <= 2'h0;
        i_wfr <= 8'h40;
        push(0, 4'hE);
        tick(100);
        chk("wfr_hold", 0, o_busy);
        rd(6, lvl(6), 6);
        wait_res(1);
        rd(6, lvl(4'hE), 4'hE);
        chk("din", 16'hA500, o_din);
        @(posedge i_clock);
        i_srst <= 1'b1;
        i_fifo_en <= 1'b1;
        i_apd_en <= 1'b1;
        i_emux_en <= 1'b1;
        i_mux_test <= 1'b0;
        tick(2);
        i_srst <= 1'b0;
        push(0, 4'h1);
        push(0, 4'h2);
        push(0, 4'h3);
        wait_idle();
        #1 chk("pwr_off", 0, o_pwr_on);
        chk("emux", 3, o_emux_sel);
        for (int i = 1; i < 4; i++) rd(0, lvl(i[3:0]), i[3:0]);
        chk("fifo_empty", 0, o_res_valid);
        conclude();
    end
endmodule
`default_nettype wire
